// ===== design/thruster_fire_pkg.sv
package thruster_fire_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int BASE_HZ = 64_000;
  localparam int PULSE_SPACING_US = 500;
  localparam int PULSE_SPACING_TICKS = BASE_HZ / 1_000_000 * PULSE_SPACING_US
                                       + (BASE_HZ % 1_000_000) * PULSE_SPACING_US / 1_000_000;
  localparam int PRESCALE_DIV = 12800;
  localparam int PRESCALE_STAGES = 8;
  // per stage terminal count (modulus minus one), stage 0 in the low nibble: 4,4,3,3,3,1,1,1
  localparam logic [31:0] PRESCALE_LAST = 32'h1113_3344;
  localparam logic [2:0] DIV5_LAST = 3'h4;
  localparam logic [3:0] DIV10_LAST = 4'h9;
  localparam int BURST_PULSES = 4;
  localparam logic [3:0] LEAD_PRESET = 4'h8;
  localparam logic [3:0] LEAD_LAST = 4'h1;
  localparam logic [3:0] PATTERN_RESET = 4'h0;

  typedef enum logic [1:0] {
    RATE_5HZ,
    RATE_1HZ,
    RATE_0P1HZ,
    RATE_0P01HZ
  } rate_t;

  typedef struct packed {
    logic ext_clk_select;
    logic manual_auto_select;
    logic advance_bypass_select;
    logic [1:0] dwell_segment;
    rate_t rate_select;
  } switch_t;

  localparam int SWITCH_W = $bits(switch_t);
endpackage

// ===== design/thruster_fire_pulse_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - four trigger outputs, one pulse each per group
// - lead segment changes every group unless bypass is selected
// - pulse starts spaced 0.5 ms apart
// - group rate selectable 5, 1, 0.1, 0.01 Hz
// - manual request fires exactly one group
// - all timing from one 64 kHz base
// - prescaler divides base by 12800
// - further divide by 5, 50, 500
// - prescaler is eight 4-bit stages
// - four-way selector routes one rate
// - one narrow start pulse per rate edge
// - start pulse launches burst and advances lead
// - start opens gate and starts step timer
// - start parallel-loads lead pattern into shifter
// - shift right once per step, four steps
// - at count four close gate, clear outputs
// - lead ring: zero, preset, shift, reload
// - bypass holds lead on chosen segment
// - external clock may replace 64 kHz base
module thruster_fire_pulse_sequencer #(
  parameter int CLK_FREQ = thruster_fire_pkg::CLK_HZ,
  parameter int BASE_FREQ = thruster_fire_pkg::BASE_HZ
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ext_clk_i,
  input wire logic manual_fire_button_i,
  input wire thruster_fire_pkg::switch_t switches_i,
  output logic [3:0] trigger_o,
  output logic burst_active_o,
  output logic [3:0] lead_segment_o
);
  import thruster_fire_pkg::*;

  typedef enum logic {S_IDLE, S_RUN} burst_state_t;

  logic [SWITCH_W+1:0] pin_raw;
  logic [SWITCH_W+1:0] sync1;
  logic [SWITCH_W+1:0] sync2;
  logic [SWITCH_W+1:0] sync3;
  logic [SWITCH_W+1:0] pin_level;
  switch_t sw;
  logic ext_clk_lvl;
  logic button_lvl;
  logic ext_clk_prev;
  logic button_prev;
  logic ext_tick;
  logic button_rise;
  logic [26:0] phase_acc;
  logic int_tick;
  logic base_tick;
  logic [3:0] stage_cnt [PRESCALE_STAGES];
  logic [PRESCALE_STAGES:0] carry;
  logic pre_tick;
  logic [2:0] div5_cnt;
  logic [3:0] div50_cnt;
  logic [3:0] div500_cnt;
  logic tick_1hz;
  logic tick_0p1hz;
  logic tick_0p01hz;
  logic [3:0] rate_ticks;
  logic [3:0] rate_onehot;
  logic sel_tick;
  logic start_pulse;
  logic [3:0] lead_ring;
  logic [3:0] next_lead;
  logic [3:0] load_pattern;
  burst_state_t state;
  logic [5:0] step_timer;
  logic [2:0] step_count;
  logic [3:0] pattern;
  logic step_end;
  logic gate_open;

  assign pin_raw = {ext_clk_i, manual_fire_button_i, switches_i};

  // three-flop sampling, a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SWITCH_W + 2; gi++) begin : g_pin_sync
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pin_level[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_level[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  assign sw = pin_level[SWITCH_W-1:0];
  assign button_lvl = pin_level[SWITCH_W];
  assign ext_clk_lvl = pin_level[SWITCH_W+1];

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_clk_prev <= 1'b0;
      button_prev <= 1'b0;
    end else begin
      ext_clk_prev <= ext_clk_lvl;
      button_prev <= button_lvl;
    end
  end

  assign ext_tick = ext_clk_lvl & ~ext_clk_prev;
  assign button_rise = button_lvl & ~button_prev;

  // 64 kHz base: fractional accumulator keeps the average rate exact
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_acc <= '0;
      int_tick <= 1'b0;
    end else if ({5'h0, phase_acc} + BASE_FREQ >= CLK_FREQ) begin
      phase_acc <= 27'({5'h0, phase_acc} + BASE_FREQ - CLK_FREQ);
      int_tick <= 1'b1;
    end else begin
      phase_acc <= 27'({5'h0, phase_acc} + BASE_FREQ);
      int_tick <= 1'b0;
    end
  end

  assign base_tick = sw.ext_clk_select ? ext_tick : int_tick;

  assign carry[0] = base_tick;
  generate
    for (gi = 0; gi < PRESCALE_STAGES; gi++) begin : g_prescale
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stage_cnt[gi] <= 4'h0;
        end else if (carry[gi]) begin
          stage_cnt[gi] <= carry[gi+1] ? 4'h0 : stage_cnt[gi] + 4'h1;
        end
      end
      assign carry[gi+1] = carry[gi] && (stage_cnt[gi] == PRESCALE_LAST[4*gi +: 4]);
    end
  endgenerate

  assign pre_tick = carry[PRESCALE_STAGES];

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div5_cnt <= 3'h0;
      div50_cnt <= 4'h0;
      div500_cnt <= 4'h0;
    end else if (pre_tick) begin
      div5_cnt <= tick_1hz ? 3'h0 : div5_cnt + 3'h1;
      if (tick_1hz) begin
        div50_cnt <= tick_0p1hz ? 4'h0 : div50_cnt + 4'h1;
        if (tick_0p1hz) begin
          div500_cnt <= tick_0p01hz ? 4'h0 : div500_cnt + 4'h1;
        end
      end
    end
  end

  assign tick_1hz = pre_tick && (div5_cnt == DIV5_LAST);
  assign tick_0p1hz = tick_1hz && (div50_cnt == DIV10_LAST);
  assign tick_0p01hz = tick_0p1hz && (div500_cnt == DIV10_LAST);

  assign rate_ticks = {tick_0p01hz, tick_0p1hz, tick_1hz, pre_tick};
  assign rate_onehot = 4'h1 << sw.rate_select;
  assign sel_tick = |(rate_ticks & rate_onehot);

  // one-cycle start pulse, auto rate or manual edge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= sw.manual_auto_select ? button_rise : sel_tick;
    end
  end

  always_comb begin
    next_lead = lead_ring;
    if (lead_ring == 4'h0 || lead_ring == LEAD_LAST) begin
      next_lead = LEAD_PRESET;
    end else begin
      next_lead = lead_ring >> 1;
    end
  end

  // advance on each start; bypass holds it
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lead_ring <= 4'h0;
    end else if (start_pulse && !sw.advance_bypass_select) begin
      lead_ring <= next_lead;
    end
  end

  assign load_pattern = sw.advance_bypass_select ? (4'h1 << sw.dwell_segment) : next_lead;

  assign step_end = base_tick && (step_timer == 6'(PULSE_SPACING_TICKS - 1));

  // a start during a burst restarts it, so a late group never merges with the old one
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= S_IDLE;
      gate_open <= 1'b0;
      step_timer <= 6'h0;
      step_count <= 3'h0;
      pattern <= PATTERN_RESET;
    end else if (start_pulse) begin
      state <= S_RUN;
      gate_open <= 1'b1;
      step_timer <= 6'h0;
      step_count <= 3'h0;
      pattern <= load_pattern;
    end else if (state == S_RUN && base_tick) begin
      step_timer <= step_end ? 6'h0 : step_timer + 6'h1;
      if (step_end) begin
        if (step_count == 3'(BURST_PULSES - 1)) begin
          state <= S_IDLE;
          gate_open <= 1'b0;
          step_count <= 3'(BURST_PULSES);
          pattern <= PATTERN_RESET;
        end else begin
          // rotate right so each output gets one pulse
          step_count <= step_count + 3'h1;
          pattern <= {pattern[0], pattern[3:1]};
        end
      end
    end
  end

  // outputs are level pulses, rising edge is what fires
  assign trigger_o = pattern;
  // gate flag is its own flop so the output needs no decode
  assign burst_active_o = gate_open;
  assign lead_segment_o = lead_ring;

  onehot_out_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $onehot0(trigger_o)) else $error("more than one trigger active");

  lead_moves_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    start_pulse && !sw.advance_bypass_select |=> lead_ring != $past(lead_ring))
    else $error("lead segment did not move");

  spacing_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    state == S_RUN && !start_pulse && !step_end |=> $stable(pattern))
    else $error("trigger changed inside a step");

  prescale_base_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    pre_tick |-> base_tick && stage_cnt[7] == 4'h1) else $error("prescaler tick misplaced");

  div_chain_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    tick_0p01hz |-> tick_0p1hz && tick_1hz && pre_tick) else $error("rate chain broken");

  auto_start_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !sw.manual_auto_select && sel_tick |=> start_pulse) else $error("rate edge gave no start");

  manual_start_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    start_pulse && sw.manual_auto_select |-> $past(button_rise))
    else $error("manual start without button edge");

  start_load_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    start_pulse |=> burst_active_o && step_timer == 6'h0 && pattern == $past(load_pattern))
    else $error("start did not load pattern");

  shift_step_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    state == S_RUN && !start_pulse && step_end && step_count < 3'h3
    |=> pattern == {$past(pattern[0]), $past(pattern[3:1])}) else $error("shift step wrong");

  burst_end_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    state == S_RUN && !start_pulse && step_end && step_count == 3'h3
    |=> !burst_active_o && trigger_o == 4'h0) else $error("burst did not close");

  ring_preset_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    start_pulse && !sw.advance_bypass_select && (lead_ring == 4'h0 || lead_ring == LEAD_LAST)
    |=> lead_ring == LEAD_PRESET) else $error("ring did not reload preset");

  bypass_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    start_pulse && sw.advance_bypass_select |=> $stable(lead_ring))
    else $error("lead advanced under bypass");

  burst_done_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    burst_active_o ##1 !burst_active_o);
  manual_fire_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    start_pulse && sw.manual_auto_select);
  bypass_fire_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    start_pulse && sw.advance_bypass_select);
  ext_clock_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    start_pulse && sw.ext_clk_select);
endmodule

// ===== tb/trigger_segment_driver.sv
`timescale 1ns/1ps
module trigger_segment_driver (
  input wire logic [3:0] trigger_i,
  input wire logic clear_i,
  output logic [3:0] seen_o,
  output int sparks_o,
  output realtime gap_o
);
  logic [3:0] prev;
  realtime last;
  initial begin
    prev = 4'h0;
    seen_o = 4'h0;
    sparks_o = 0;
    gap_o = 0.0;
    last = 0.0;
  end
  // edge sparks
  // the pulse is differentiated, so a held level sparks only once
  always @(trigger_i or clear_i) begin
    if (clear_i) begin
      seen_o = 4'h0;
    end
    for (int i = 0; i < 4; i++) begin
      if (trigger_i[i] === 1'b1 && prev[i] !== 1'b1) begin
        sparks_o++;
        seen_o[i] = 1'b1;
        gap_o = $realtime - last;
        last = $realtime;
      end
    end
    prev = trigger_i;
  end
endmodule

// ===== tb/test_thruster_fire_pulse_sequencer.sv
`timescale 1ns/1ps
module test_thruster_fire_pulse_sequencer;
  import thruster_fire_pkg::*;
  localparam int CLKF = 100_000_000;
  // fast base keeps a 5 pps group at 16000 mclk
  localparam int BASEF = 80_000_000;
  localparam int STEP = 32 * (CLKF / 1000) / (BASEF / 1000);
  localparam int GROUP = 12800 * (CLKF / 1000) / (BASEF / 1000);
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ext_clk_i = 1'b0;
  logic manual_fire_button_i = 1'b0;
  switch_t switches_i = '0;
  logic [3:0] trigger_o;
  logic [3:0] lead_segment_o;
  logic burst_active_o;
  logic clear = 1'b0;
  logic [3:0] seen;
  int sparks;
  realtime gap;
  realtime t_rise;
  bit ext_run = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  logic [3:0] lead = 4'h0;

  thruster_fire_pulse_sequencer #(.CLK_FREQ(CLKF), .BASE_FREQ(BASEF)) dut (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ext_clk_i(ext_clk_i),
    .manual_fire_button_i(manual_fire_button_i),
    .switches_i(switches_i),
    .trigger_o(trigger_o),
    .burst_active_o(burst_active_o),
    .lead_segment_o(lead_segment_o)
  );
  trigger_segment_driver engine (
    .trigger_i(trigger_o),
    .clear_i(clear),
    .seen_o(seen),
    .sparks_o(sparks),
    .gap_o(gap)
  );

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // external base of 6 mclk period, only while selected
  always begin
    @(posedge mclk_i);
    if (ext_run) begin
      repeat (2) @(posedge mclk_i);
      #1 ext_clk_i = ~ext_clk_i;
    end
  end

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask
  function automatic logic [3:0] next_lead(input logic [3:0] l);
    return (l == 4'h0 || l == 4'h1) ? 4'h8 : l >> 1;
  endfunction
  task automatic press(input int hold);
    wt(1);
    manual_fire_button_i = 1'b1;
    wt(hold);
    manual_fire_button_i = 1'b0;
  endtask
  task automatic burst(input logic [3:0] first, input int step);
    int n;
    int s0;
    logic [3:0] p;
    n = 0;
    p = first;
    s0 = sparks;
    clear = 1'b1;
    #1 clear = 1'b0;
    while (burst_active_o !== 1'b1 && n < 40000) begin
      wt(1);
      n++;
    end
    t_rise = $realtime;
    check(1, n < 40000);
    check(first, trigger_o);
    check(lead, lead_segment_o);
    wt(step / 2);
    for (int k = 0; k < 4; k++) begin
      check(p, trigger_o);
      p = {p[0], p[3:1]};
      wt(step);
    end
    check(0, {trigger_o, burst_active_o});
    check(4'hf, seen);
    check(4, sparks - s0);
    check(1, gap == step * 10.0);
  endtask

  initial begin
    realtime t0;
    void'($urandom(79));
    switches_i.manual_auto_select = 1'b1;
    wt(5);
    rstn_i = 1'b1;
    check(0, {trigger_o, burst_active_o, lead_segment_o});
    wt(10);
    // first shot holds the button well past its burst
    for (int i = 0; i < 5; i++) begin
      lead = next_lead(lead);
      fork
        press(i == 0 ? 400 : 5 + $urandom_range(40));
        burst(lead, STEP);
      join
      wt(20);
      check(0, burst_active_o);
      $display("manual shot %0d done", i);
    end
    switches_i.advance_bypass_select = 1'b1;
    for (int d = 0; d < 4; d++) begin
      switches_i.dwell_segment = 2'(d);
      wt(10);
      fork
        press(10);
        burst(4'h1 << d, STEP);
      join
    end
    $display("bypass done");
    switches_i.advance_bypass_select = 1'b0;
    switches_i.ext_clk_select = 1'b1;
    ext_run = 1'b1;
    lead = next_lead(lead);
    wt(10);
    fork
      press(10);
      burst(lead, 192);
    join
    ext_run = 1'b0;
    switches_i.ext_clk_select = 1'b0;
    switches_i.manual_auto_select = 1'b0;
    switches_i.rate_select = RATE_5HZ;
    press(10);
    wt(30);
    check(0, burst_active_o);
    $display("external base done");
    lead = next_lead(lead);
    burst(lead, STEP);
    t0 = t_rise;
    lead = next_lead(lead);
    burst(lead, STEP);
    check(1, t_rise - t0 == GROUP * 10.0);
    $display("auto rate done");
    // slower rates must stay silent for longer than a 5 pps period
    for (int r = 1; r < 4; r++) begin
      switches_i.rate_select = rate_t'(r);
      t0 = sparks;
      wt(GROUP + 1000);
      check(t0, sparks);
      $display("rate %0d window done", r);
    end
    results();
  end

  // tests take about 85k mclk
  initial begin
    #(95_000 * 10);
    bad_count++;
    results();
  end
endmodule
